// file: src/tpad_consts.svh
// Timing, angle and level constants of the touch phase-angle dimmer
`ifndef TPAD_CONSTS_SVH
`define TPAD_CONSTS_SVH
// ---------------------------------------------------------------
// Clock and line
// ---------------------------------------------------------------
`define TPAD_CLK_MHZ       200
`define TPAD_LINE_HZ       60
`define TPAD_DEG_PER_LINE  360
`define TPAD_HALF_DEG      9'h0B4
`define TPAD_LAST_DEG      9'h167
// ---------------------------------------------------------------
// Firing angle and brightness levels
// ---------------------------------------------------------------
`define TPAD_MIN_DEG       9'h029
`define TPAD_MAX_DEG       9'h09F
`define TPAD_DEG_SPAN      14'h0076
`define TPAD_LVL_STEPS     14'h0052
`define TPAD_LVL_MAX       7'h52
`define TPAD_LVL_MIN       7'h00
`define TPAD_FIRST_OUTER_BP  7'h1C
`define TPAD_SECOND_OUTER_BP 7'h1C
`define TPAD_FIRST_INNER_BP  7'h00
`define TPAD_SECOND_INNER_BP 7'h00
`define TPAD_SWEEP_STEP    7'h02
`define TPAD_FAST_CLKS     6'h02
`define TPAD_SLOW_CLKS     6'h04
// ---------------------------------------------------------------
// Times, counted in line cycles or system clocks
// ---------------------------------------------------------------
`define TPAD_DWELL_MS      500
`define TPAD_DWELL_CLKS    6'((`TPAD_DWELL_MS * `TPAD_LINE_HZ) / 1000)
`define TPAD_SHORT_MS      32
`define TPAD_SHORT_CLKS    6'((`TPAD_SHORT_MS * `TPAD_LINE_HZ + 999) / 1000)
`define TPAD_LONG_MS       332
`define TPAD_LONG_CLKS     6'((`TPAD_LONG_MS * `TPAD_LINE_HZ + 999) / 1000)
`define TPAD_PULSE_US      50
`define TPAD_PULSE_CYC     (`TPAD_PULSE_US * `TPAD_CLK_MHZ)
`define TPAD_HOLDUP_MS     1000
`define TPAD_HOLDUP_CYC    (`TPAD_HOLDUP_MS * 1000 * `TPAD_CLK_MHZ)
`endif

// file: src/tpad_dimmer.sv
// Touch phase-angle dimmer: touch timing, levels, sweep, slow dim
//
// Overview of operation
// - Lock touch, sweep and firing-angle timing to the line sync
// - One low firing pulse per half cycle
// - Fire between 41 and 159 degrees
// - Momentary touch toggles load on or off
// - Held touch sweeps, reversing at both ends
// - Thresholds scale with 60 Hz line
// - Each slow-dim falling edge lowers one step
// - Off by slow dim ignores further clocks
// - Touch active blocks the slow-dim input
// - Remote touch is local touch, active high
// - Memory: store on off, restore on on
// - Memory: first held touch starts at minimum
// - No memory: held touch starts per level
// - Fast region steps every 2 line clocks
// - Slow region steps every 4 line clocks
// - Hold minimum for about 500 ms
// - Full sweep each way takes about 1.83 seconds
// - Keep state 1 s, then switch off
`timescale 1ns/1ps
`include "tpad_consts.svh"
module tpad_dimmer #(
   parameter int PULSE_CYC  = `TPAD_PULSE_CYC,
   parameter int HOLDUP_CYC = `TPAD_HOLDUP_CYC
) (
   input  wire logic        sys_clk,
   input  wire logic        resetn,
   input  wire logic        line_sync,
   input  wire logic        touch_local_n,
   input  wire logic        touch_remote,
   input  wire logic        doze_clk,
   input  wire logic        cfg_memory,
   input  wire logic        cfg_reverse,
   input  wire logic        cfg_toggle_only,
   output logic             triac_fire_n,
   output logic             load_on,
   output tpad_pkg::tpad_lvl_t bright_lvl,
   output logic             line_locked
);
   import tpad_pkg::*;

   // ---------------------------------------------------------------
   // Declarations
   // ---------------------------------------------------------------
   tpad_deg_t      deg;
   logic           deg_step;
   logic           line_tick;
   logic           sync_ok;
   tpad_touch_st_t st_r;
   logic [5:0]     cnt_r;
   logic [5:0]     pace_r;
   logic [5:0]     pace_lim;
   logic           on_r;
   tpad_lvl_t      lvl_r;
   logic           dir_up_r;
   tpad_lvl_t      mem_lvl_r;
   logic           mem_valid_r;
   logic           long_seen_r;
   logic           doze_d_r;
   logic           sync_ok_d_r;
   tpad_deg_t      ang_r;
   logic [13:0]    ang_prod;
   logic           touch_act;
   logic           doze_fall;
   logic           press_end;
   logic           toggle_ev;
   logic           long_ev;
   logic           sweep_start;
   logic           sweep_tick;
   logic           sweep_step;
   logic           doze_ev;
   logic           sync_lost;
   tpad_lvl_t      start_lvl;
   logic           start_up;

   // ---------------------------------------------------------------
   // Line lock and firing pulse
   // ---------------------------------------------------------------
   tpad_line_pll #(
      .HOLDUP_CYC (HOLDUP_CYC)
   ) u_pll (
      .sys_clk   (sys_clk),
      .resetn    (resetn),
      .line_sync (line_sync),
      .deg       (deg),
      .deg_step  (deg_step),
      .line_tick (line_tick),
      .sync_ok   (sync_ok)
   );

   tpad_fire_gen #(
      .PULSE_CYC (PULSE_CYC)
   ) u_fire (
      .sys_clk      (sys_clk),
      .resetn       (resetn),
      .deg          (deg),
      .deg_step     (deg_step),
      .fire_en      (on_r & sync_ok),
      .fire_deg     (ang_r),
      .triac_fire_n (triac_fire_n)
   );

   // ---------------------------------------------------------------
   // Input events
   // ---------------------------------------------------------------
   assign touch_act = ~touch_local_n | touch_remote;
   assign doze_fall = doze_d_r & ~doze_clk;
   assign sync_lost = sync_ok_d_r & ~sync_ok;

   // Press and sweep logic only looks at touch on line ticks, so durations are line cycles
   assign press_end   = line_tick && st_r == TPAD_ST_PRESS && !touch_act;
   assign toggle_ev   = press_end && cnt_r >= `TPAD_SHORT_CLKS;
   assign long_ev     = line_tick && st_r == TPAD_ST_PRESS && touch_act &&
                        cnt_r >= `TPAD_LONG_CLKS;
   assign sweep_start = long_ev && !cfg_toggle_only;
   assign sweep_tick  = line_tick && st_r == TPAD_ST_SWEEP && touch_act;
   assign sweep_step  = sweep_tick && (pace_r + 6'h01 >= pace_lim);
   assign doze_ev     = doze_fall && st_r == TPAD_ST_IDLE && !touch_act &&
                        on_r && sync_ok;

   always_ff @(posedge sys_clk) begin
      if (!resetn) begin
         doze_d_r    <= 1'b1;
         sync_ok_d_r <= 1'b0;
      end else begin
         doze_d_r    <= doze_clk;
         sync_ok_d_r <= sync_ok;
      end
   end

   // ---------------------------------------------------------------
   // Touch duration state machine
   // ---------------------------------------------------------------
   always_ff @(posedge sys_clk) begin
      if (!resetn) begin
         st_r  <= TPAD_ST_IDLE;
         cnt_r <= 6'h00;
      end else if (sync_lost) begin
         st_r <= TPAD_ST_IDLE;
      end else if (line_tick) begin
         case (st_r)
            TPAD_ST_IDLE: begin
               if (touch_act) begin
                  st_r  <= TPAD_ST_PRESS;
                  cnt_r <= 6'h01;
               end
            end
            TPAD_ST_PRESS: begin
               if (!touch_act) st_r <= TPAD_ST_IDLE;
               else if (long_ev) st_r <= cfg_toggle_only ? TPAD_ST_HOLD : TPAD_ST_SWEEP;
               else cnt_r <= cnt_r + 6'h01;
            end
            TPAD_ST_SWEEP,
            TPAD_ST_HOLD: begin
               if (!touch_act) st_r <= TPAD_ST_IDLE;
            end
            default: st_r <= TPAD_ST_IDLE;
         endcase
      end
   end

   // ---------------------------------------------------------------
   // Sweep pacing
   // ---------------------------------------------------------------
   always_comb begin
      if (lvl_r == `TPAD_FIRST_INNER_BP && !dir_up_r) begin
         pace_lim = `TPAD_DWELL_CLKS;
      end else if (lvl_r > `TPAD_FIRST_OUTER_BP ||
                   (lvl_r == `TPAD_SECOND_OUTER_BP && dir_up_r)) begin
         pace_lim = `TPAD_FAST_CLKS;
      end else begin
         pace_lim = `TPAD_SLOW_CLKS;
      end
   end

   always_ff @(posedge sys_clk) begin
      if (!resetn) begin
         pace_r <= 6'h00;
      end else if (sweep_start || sweep_step) begin
         pace_r <= 6'h00;
      end else if (sweep_tick) begin
         pace_r <= pace_r + 6'h01;
      end
   end

   // ---------------------------------------------------------------
   // Sweep start point
   // ---------------------------------------------------------------
   always_comb begin
      start_lvl = lvl_r;
      start_up  = 1'b1;
      if (!on_r) begin
         start_lvl = `TPAD_LVL_MIN;
         if (cfg_memory && long_seen_r && mem_valid_r) begin
            start_lvl = mem_lvl_r;
            start_up  = mem_lvl_r != `TPAD_LVL_MAX;
         end
      end else if (lvl_r == `TPAD_LVL_MAX) begin
         start_up = 1'b0;
      end else if (lvl_r != `TPAD_LVL_MIN) begin
         start_up = cfg_reverse ? !dir_up_r : 1'b1;
      end
   end

   // ---------------------------------------------------------------
   // Load state, level and direction
   // ---------------------------------------------------------------
   always_ff @(posedge sys_clk) begin
      if (!resetn) begin
         on_r     <= 1'b0;
         lvl_r    <= `TPAD_LVL_MAX;
         dir_up_r <= 1'b1;
      end else if (sync_lost) begin
         on_r <= 1'b0;
      end else if (toggle_ev) begin
         on_r <= !on_r;
         if (!on_r) begin
            lvl_r <= (cfg_memory && mem_valid_r) ? mem_lvl_r : `TPAD_LVL_MAX;
         end
      end else if (sweep_start) begin
         on_r     <= 1'b1;
         lvl_r    <= start_lvl;
         dir_up_r <= start_up;
      end else if (sweep_step) begin
         if (dir_up_r) begin
            if (lvl_r >= `TPAD_LVL_MAX - `TPAD_SWEEP_STEP) begin
               lvl_r    <= `TPAD_LVL_MAX;
               dir_up_r <= 1'b0;
            end else begin
               lvl_r <= lvl_r + `TPAD_SWEEP_STEP;
            end
         end else if (lvl_r == `TPAD_LVL_MIN) begin
            dir_up_r <= 1'b1;
         end else if (lvl_r <= `TPAD_SWEEP_STEP) begin
            lvl_r <= `TPAD_LVL_MIN;
         end else begin
            lvl_r <= lvl_r - `TPAD_SWEEP_STEP;
         end
      end else if (doze_ev) begin
         if (lvl_r == `TPAD_LVL_MIN) on_r <= 1'b0;
         else lvl_r <= lvl_r - 7'h01;
      end
   end

   // ---------------------------------------------------------------
   // Brightness memory
   // ---------------------------------------------------------------
   always_ff @(posedge sys_clk) begin
      if (!resetn) begin
         mem_lvl_r   <= `TPAD_LVL_MAX;
         mem_valid_r <= 1'b0;
         long_seen_r <= 1'b0;
      end else begin
         if (toggle_ev && on_r && cfg_memory) begin
            mem_lvl_r   <= lvl_r;
            mem_valid_r <= 1'b1;
         end
         if (sweep_start) long_seen_r <= 1'b1;
      end
   end

   // ---------------------------------------------------------------
   // Level to firing angle
   // ---------------------------------------------------------------
   assign ang_prod = 14'(lvl_r * `TPAD_DEG_SPAN);

   always_ff @(posedge sys_clk) begin
      if (!resetn) begin
         ang_r <= `TPAD_MAX_DEG;
      end else begin
         ang_r <= `TPAD_MIN_DEG + 9'(ang_prod / `TPAD_LVL_STEPS);
      end
   end

   assign load_on     = on_r;
   assign bright_lvl  = lvl_r;
   assign line_locked = sync_ok;

   // ---------------------------------------------------------------
   // Checks
   // ---------------------------------------------------------------
   toggle_off_a: assert property (
      @(posedge sys_clk) disable iff (!resetn)
      (toggle_ev && on_r) |=> !on_r)
      else $error("momentary touch left the load on");
   toggle_on_a: assert property (
      @(posedge sys_clk) disable iff (!resetn)
      (toggle_ev && !on_r && !(cfg_memory && mem_valid_r)) |=> on_r && lvl_r == `TPAD_LVL_MAX)
      else $error("first switch-on not at full brightness");
   doze_step_a: assert property (
      @(posedge sys_clk) disable iff (!resetn)
      (doze_ev && lvl_r != `TPAD_LVL_MIN) |=> lvl_r == $past(lvl_r) - 7'h01)
      else $error("slow-dim edge did not lower one step");
   doze_off_a: assert property (
      @(posedge sys_clk) disable iff (!resetn)
      (!on_r && doze_fall && !line_tick) |=> !on_r)
      else $error("slow-dim clock turned the load on");
   doze_block_a: assert property (
      @(posedge sys_clk) disable iff (!resetn)
      (doze_fall && touch_act && !line_tick) |=> $stable(lvl_r) && $stable(on_r))
      else $error("slow-dim acted during touch");
   fast_rate_a: assert property (
      @(posedge sys_clk) disable iff (!resetn)
      (sweep_tick && pace_r == 6'h01 && dir_up_r && lvl_r > `TPAD_FIRST_OUTER_BP &&
       lvl_r < `TPAD_LVL_MAX - `TPAD_SWEEP_STEP) |=> lvl_r == $past(lvl_r) + `TPAD_SWEEP_STEP)
      else $error("fast sweep step missed");
   no_sweep_a: assert property (
      @(posedge sys_clk) disable iff (!resetn)
      (st_r == TPAD_ST_SWEEP && $past(st_r) != TPAD_ST_SWEEP) |-> !$past(cfg_toggle_only))
      else $error("toggle-only variant entered sweep");
   line_loss_a: assert property (
      @(posedge sys_clk) disable iff (!resetn)
      sync_lost |=> !on_r ##1 !on_r)
      else $error("load stayed on after long line loss");
endmodule : tpad_dimmer

// file: src/tpad_fire_gen.sv
// Firing pulse generator: one low pulse per half cycle at the set angle
`timescale 1ns/1ps
`include "tpad_consts.svh"
module tpad_fire_gen #(
   parameter int PULSE_CYC = `TPAD_PULSE_CYC
) (
   input  wire logic        sys_clk,
   input  wire logic        resetn,
   input  tpad_pkg::tpad_deg_t deg,
   input  wire logic        deg_step,
   input  wire logic        fire_en,
   input  tpad_pkg::tpad_deg_t fire_deg,
   output logic             triac_fire_n
);
   import tpad_pkg::*;
   logic        fire_start;
   logic [15:0] width_r;
   logic        half_d_r;
   logic        fired_half_r;
   logic        half_flip;
   tpad_deg_t   half_deg;
   logic        gate_d_r;
   logic [1:0]  pulses_r;

   assign half_flip = half_d_r != (deg >= `TPAD_HALF_DEG);
   assign half_deg  = (deg >= `TPAD_HALF_DEG) ? deg - `TPAD_HALF_DEG : deg;

   // First step at or past the angle: a level lowered mid half cycle cannot skip the pulse
   assign fire_start = fire_en && deg_step && !fired_half_r &&
                       half_deg >= fire_deg && half_deg <= `TPAD_MAX_DEG;

   always_ff @(posedge sys_clk) begin
      if (!resetn) begin
         width_r      <= 16'h0000;
         triac_fire_n <= 1'b1;
      end else if (fire_start) begin
         width_r      <= 16'(PULSE_CYC - 1);
         triac_fire_n <= 1'b0;
      end else if (width_r != 16'h0000) begin
         width_r <= width_r - 16'h0001;
      end else begin
         triac_fire_n <= 1'b1;
      end
   end

   // Tracks whether this half cycle has fired already
   always_ff @(posedge sys_clk) begin
      if (!resetn) begin
         half_d_r     <= 1'b0;
         fired_half_r <= 1'b0;
      end else begin
         half_d_r <= (deg >= `TPAD_HALF_DEG);
         if (fire_start) fired_half_r <= 1'b1;
         else if (half_flip || deg == 9'h000) fired_half_r <= 1'b0;
      end
   end

   // Output pulses seen in this half cycle, for the once-per-half check
   always_ff @(posedge sys_clk) begin
      if (!resetn) begin
         gate_d_r <= 1'b1;
         pulses_r <= 2'h0;
      end else begin
         gate_d_r <= triac_fire_n;
         if (half_flip) begin
            pulses_r <= 2'h0;
         end else if (gate_d_r && !triac_fire_n && pulses_r != 2'h3) begin
            pulses_r <= pulses_r + 2'h1;
         end
      end
   end

   once_per_half_a: assert property (
      @(posedge sys_clk) disable iff (!resetn)
      pulses_r <= 2'h1)
      else $error("second firing pulse in one half cycle");
   fire_range_a: assert property (
      @(posedge sys_clk) disable iff (!resetn)
      fire_start |-> (fire_deg >= `TPAD_MIN_DEG && fire_deg <= `TPAD_MAX_DEG))
      else $error("firing angle outside 41 to 159 degrees");
   pulse_low_a: assert property (
      @(posedge sys_clk) disable iff (!resetn)
      fire_start |=> !triac_fire_n)
      else $error("firing pulse not driven low");
endmodule : tpad_fire_gen

// file: src/tpad_line_pll.sv
// Digital line lock: line-cycle phase in degrees and line-cycle ticks
`timescale 1ns/1ps
`include "tpad_consts.svh"
module tpad_line_pll #(
   parameter int HOLDUP_CYC = `TPAD_HOLDUP_CYC
) (
   input  wire logic        sys_clk,
   input  wire logic        resetn,
   input  wire logic        line_sync,
   output tpad_pkg::tpad_deg_t deg,
   output logic             deg_step,
   output logic             line_tick,
   output logic             sync_ok
);
   import tpad_pkg::*;
   logic        sync_d_r;
   logic        sync_rise;
   logic [27:0] per_cnt_r;
   logic [27:0] per_r;
   logic [1:0]  edges_r;
   logic [28:0] acc_r;
   logic [28:0] acc_nxt;
   tpad_deg_t   deg_r;
   logic        step_r;
   logic        tick_r;
   logic        ok_r;

   assign sync_rise = line_sync & ~sync_d_r;
   assign acc_nxt   = acc_r + 29'(`TPAD_DEG_PER_LINE);

   // ---------------------------------------------------------------
   // Period measurement and loss of line
   // ---------------------------------------------------------------
   always_ff @(posedge sys_clk) begin
      if (!resetn) begin
         sync_d_r  <= 1'b1;  // A line already high at release is not an edge
         per_cnt_r <= 28'h0000000;
         per_r     <= 28'h0000000;
         edges_r   <= 2'h0;
         ok_r      <= 1'b0;
      end else begin
         sync_d_r <= line_sync;
         if (sync_rise) begin
            per_r     <= per_cnt_r + 28'h0000001;
            per_cnt_r <= 28'h0000000;
            if (edges_r != 2'h2) edges_r <= edges_r + 2'h1;
            if (edges_r == 2'h2) ok_r <= 1'b1;
         end else if (per_cnt_r >= 28'(HOLDUP_CYC)) begin
            ok_r    <= 1'b0;  // Line gone too long: relock from scratch
            edges_r <= 2'h0;
         end else begin
            per_cnt_r <= per_cnt_r + 28'h0000001;
         end
      end
   end

   // ---------------------------------------------------------------
   // Degree oscillator, realigned at each line edge
   // ---------------------------------------------------------------
   always_ff @(posedge sys_clk) begin
      if (!resetn) begin
         acc_r  <= 29'h00000000;
         deg_r  <= 9'h000;
         step_r <= 1'b0;
         tick_r <= 1'b0;
      end else begin
         step_r <= 1'b0;
         tick_r <= sync_rise & ok_r;
         if (sync_rise) begin
            acc_r <= 29'h00000000;
            deg_r <= 9'h000;
         end else if (ok_r && acc_nxt >= {1'b0, per_r}) begin
            acc_r  <= acc_nxt - {1'b0, per_r};
            step_r <= 1'b1;
            if (deg_r != `TPAD_LAST_DEG) deg_r <= deg_r + 9'h001;
         end else if (ok_r) begin
            acc_r <= acc_nxt;
         end
      end
   end

   assign deg       = deg_r;
   assign deg_step  = step_r;
   assign line_tick = tick_r;
   assign sync_ok   = ok_r;

   sync_align_a: assert property (
      @(posedge sys_clk) disable iff (!resetn)
      (sync_rise && ok_r) |=> (deg_r == 9'h000) && tick_r)
      else $error("phase not realigned to line edge");
   tick_cause_a: assert property (
      @(posedge sys_clk) disable iff (!resetn)
      tick_r |-> $past(sync_rise) && $past(ok_r))
      else $error("line tick without a locked line edge");
endmodule : tpad_line_pll

// file: src/tpad_pkg.sv
// Types shared by the touch phase-angle dimmer modules
package tpad_pkg;
   typedef logic [6:0] tpad_lvl_t;
   typedef logic [8:0] tpad_deg_t;
   typedef enum logic [1:0] {
      TPAD_ST_IDLE,
      TPAD_ST_PRESS,
      TPAD_ST_SWEEP,
      TPAD_ST_HOLD
   } tpad_touch_st_t;
endpackage : tpad_pkg

// file: verification/tb_top.sv
// Self-checking bench of the touch phase-angle dimmer
`timescale 1ns/1ps
module tb_top;
   import tpad_pkg::*;
   localparam int P = 720;
   logic        sys_clk = 1'b0;
   logic        resetn, line_sync, touch_local_n, touch_remote, doze_clk;
   logic        cfg_memory, cfg_reverse, cfg_toggle_only, line_stop;
   logic        triac_fire_n, load_on, line_locked;
   tpad_lvl_t   bright_lvl, lvl_a, lvl_b;
   logic [3:0]  fires;
   logic [11:0] fire_pos;
   logic [31:0] seed;
   int          num_errors = 0;
   int          total_checks = 0;
   int          cyc = 0;
   int          n;

   always #2.5 sys_clk = ~sys_clk;

   tpad_dimmer #(.PULSE_CYC(20), .HOLDUP_CYC(2000)) tpad_dimmer_i (
      .sys_clk(sys_clk), .resetn(resetn), .line_sync(line_sync),
      .touch_local_n(touch_local_n), .touch_remote(touch_remote), .doze_clk(doze_clk),
      .cfg_memory(cfg_memory), .cfg_reverse(cfg_reverse),
      .cfg_toggle_only(cfg_toggle_only), .triac_fire_n(triac_fire_n),
      .load_on(load_on), .bright_lvl(bright_lvl), .line_locked(line_locked)
   );
   tpad_triac_model #(.PERIOD(P)) tpad_triac_model_i (
      .sys_clk(sys_clk), .triac_fire_n(triac_fire_n), .line_sync(line_sync),
      .line_stop(line_stop),
      .fires(fires), .fire_pos(fire_pos)
   );
   // -------------------------------------------
   // Helpers
   // -------------------------------------------
   task automatic end_sim();
      $display("checks %0d errors %0d", total_checks, num_errors);
      if (num_errors == 0 && total_checks > 0) begin
         $display("DONE - PASS");
      end else begin
         $display("DONE - FAIL");
      end
      $finish;
   endtask : end_sim

   task automatic check(input logic [11:0] seen, input logic [11:0] exp);
      total_checks++;
      if (seen !== exp) begin
         num_errors++;
         $display("ERROR %0t seen %0d expected %0d", $time, seen, exp);
      end
   endtask : check

   function automatic logic [31:0] xs(input logic [31:0] s);
      logic [31:0] t;
      t = s ^ (s << 13);
      t = t ^ (t >> 17);
      return t ^ (t << 5);
   endfunction : xs

   task automatic step(input int k);
      repeat (k) @(posedge sys_clk);
      #1;
   endtask : step

   task automatic touch(input logic rem, input int per);
      @(posedge line_sync);
      step(P / 4);
      if (rem) begin
         touch_remote = 1'b1;
      end else begin
         touch_local_n = 1'b0;
      end
      step(per * P);
      touch_remote = 1'b0;
      touch_local_n = 1'b1;
      step(2 * P);
   endtask : touch

   task automatic doze(input int k);
      repeat (k) begin
         doze_clk = 1'b0;
         step(2);
         doze_clk = 1'b1;
         step(2);
      end
   endtask : doze

   task automatic hold();
      @(posedge line_sync);
      step(P / 4);
      touch_local_n = 1'b0;
      step(22 * P);
      lvl_a = bright_lvl;
      step(4 * P);
      lvl_b = bright_lvl;
      touch_local_n = 1'b1;
      step(2 * P);
   endtask : hold

   always @(posedge sys_clk) begin
      cyc++;
      if (cyc == 95000) begin
         num_errors++;
         end_sim();
      end
   end
   // -------------------------------------------
   // Main sequence
   // -------------------------------------------
   initial begin
      resetn = 1'b0;
      touch_local_n = 1'b1;
      touch_remote = 1'b0;
      doze_clk = 1'b1;
      cfg_memory = 1'b1;
      cfg_reverse = 1'b0;
      cfg_toggle_only = 1'b0;
      line_stop = 1'b0;
      seed = 32'h6796;
      step(6);
      check(load_on, 0);
      check(bright_lvl, 82);
      resetn = 1'b1;
      n = 0;
      while (line_locked !== 1'b1 && n < 5 * P) begin
         step(1);
         n++;
      end
      check(line_locked, 1);
      step(2 * P);
      check(fires, 0);
      seed = xs(seed);
      touch(1'b0, 3 + int'(seed % 6));
      check(load_on, 1);
      check(bright_lvl, 82);
      check(fires, 2);
      check(fire_pos >= 12'd312 && fire_pos <= 12'd328, 1);
      // Held touch from maximum sweeps down at the fast pace
      hold();
      check(lvl_a - lvl_b, 4);
      lvl_a = bright_lvl;
      touch(1'b1, 4);
      check(load_on, 0);
      touch(1'b1, 3);
      check(bright_lvl, lvl_a);
      seed = xs(seed);
      n = 1 + int'(seed % 20);
      doze(n);
      check(bright_lvl, lvl_a - n);
      @(posedge line_sync);
      step(P / 4);
      touch_local_n = 1'b0;
      doze(3);
      touch_local_n = 1'b1;
      check(bright_lvl, lvl_a - n);
      doze(int'(lvl_a) - n + 1);
      check(load_on, 0);
      doze(5);
      step(2 * P);
      check(load_on, 0);
      check(fires, 0);
      cfg_toggle_only = 1'b1;
      touch(1'b0, 22);
      check(load_on, 0);
      touch(1'b0, 3);
      check(load_on, 1);
      check(bright_lvl, lvl_a);
      // Held touch from an intermediate level sweeps up, then turns at maximum
      cfg_toggle_only = 1'b0;
      hold();
      check(lvl_b - lvl_a, 4);
      check(lvl_b, 82);
      // Line gone longer than the hold-up time: lock lost, load off, level kept
      line_stop = 1'b1;
      step(3 * P);
      check(line_locked, 0);
      check(load_on, 0);
      check(bright_lvl, 82);
      end_sim();
   end
endmodule : tb_top

// file: verification/tpad_triac_model.sv
// Line source and triac gate observer for the dimmer bench
`timescale 1ns/1ps
module tpad_triac_model #(
   parameter int PERIOD = 720
) (
   input  wire logic        sys_clk,
   input  wire logic        triac_fire_n,
   input  wire logic        line_stop,
   output logic             line_sync,
   output logic [3:0]       fires,
   output logic [11:0]      fire_pos
);
   logic [11:0] ph_r = 12'h000;
   logic [3:0]  cnt_r = 4'h0;
   logic        gate_r = 1'b1;
   // -------------------------------------------
   // Line square wave, rising edge starts a cycle
   // -------------------------------------------
   assign line_sync = !line_stop && (ph_r < 12'(PERIOD / 2));
   always_ff @(posedge sys_clk) begin
      ph_r <= (ph_r == 12'(PERIOD - 1)) ? 12'h000 : ph_r + 12'h001;
   end
   // -------------------------------------------
   // Gate pulses counted per line cycle
   // -------------------------------------------
   always_ff @(posedge sys_clk) begin
      gate_r <= triac_fire_n;
      if (ph_r == 12'h000) begin
         fires <= cnt_r;
         cnt_r <= 4'h0;
      end else if (gate_r && !triac_fire_n) begin
         cnt_r <= cnt_r + 4'h1;
         if (cnt_r == 4'h0) begin
            fire_pos <= ph_r;
         end
      end
   end
endmodule : tpad_triac_model
